// file: design/lsr_pkg.sv
// Purpose: shared constants for the record recency and checksum unit
// Assumes: one 20 MHz core clock
// Notes: record byte positions count from 1 in checksum stream order
package lsr_pkg;
  localparam int CLK_HZ = 20_000_000;
  localparam logic [31:0] INC_UNUSED = 32'h8000_0000;
  localparam logic [31:0] INC_FIRST = 32'h8000_0001;
  localparam logic [31:0] INC_MAX = 32'h7FFF_FFFF;
  localparam logic [15:0] AGE_ZERO = 16'h0000;
  localparam logic [15:0] MAX_AGE = 16'h0E10;
  localparam logic [15:0] MAX_AGE_DIFF_DEF = 16'h0384;
  // Stream positions of the two checksum bytes (after A0, A1, B0..B17)
  localparam logic [15:0] CSUM_POS_HI = 16'h0015;
  localparam logic [15:0] CSUM_POS_LO = 16'h0016;
  localparam logic [7:0] CSUM_ZERO_BYTE = 8'h00;
  localparam logic [8:0] MOD_FLETCHER = 9'h0FF;
  // Cost numerator for a rate given in kbaud: 1.0625e12 / 1e3
  localparam logic [31:0] COST_NUM_KBAUD = 32'h3F54_76A0;
  localparam logic [7:0] COST_SCALE_DEF = 8'h01;
  localparam logic [15:0] COST_MAX = 16'hFFFF;
  localparam int DIV_STEPS = 40;

  typedef enum logic [1:0] {
    INC_IDLE = 2'b01,
    INC_FLUSH = 2'b10
  } inc_state_t;

  typedef enum logic [1:0] {
    DIV_IDLE = 2'b01,
    DIV_RUN = 2'b10
  } div_state_t;
endpackage : lsr_pkg

// file: design/fletcher_accum.sv
// Purpose: one-byte-per-step Fletcher running sums, modulo 255
// Assumes: clear together with step restarts the sums at this byte
// Notes: sums stay in 0..254 so a single conditional subtract suffices
`timescale 1ns/1ns
`default_nettype none
module fletcher_accum
  import lsr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic clear,
  input wire logic step,
  input wire logic [7:0] data,
  output logic [7:0] sum0,
  output logic [7:0] sum1
);
  logic [7:0] next_sum0;
  logic [7:0] next_sum1;
  logic [8:0] add0;
  logic [8:0] add1;

  always_comb begin
    // First byte of a stream must count, so clear starts from zero sums
    add0 = (clear ? 9'h000 : {1'b0, sum0}) + {1'b0, data};
    if (add0 >= MOD_FLETCHER) begin
      add0 = add0 - MOD_FLETCHER;
    end
    add1 = (clear ? 9'h000 : {1'b0, sum1}) + add0;
    if (add1 >= MOD_FLETCHER) begin
      add1 = add1 - MOD_FLETCHER;
    end
    next_sum0 = sum0;
    next_sum1 = sum1;
    if (step) begin
      next_sum0 = add0[7:0];
      next_sum1 = add1[7:0];
    end else if (clear) begin
      next_sum0 = 8'h00;
      next_sum1 = 8'h00;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      sum0 <= 8'h00;
      sum1 <= 8'h00;
    end else begin
      sum0 <= next_sum0;
      sum1 <= next_sum1;
    end
  end
endmodule : fletcher_accum
`default_nettype wire

// file: design/lsr_recency_unit.sv
// Purpose: record incarnation issue, recency compare, checksum, link cost
// Assumes: all request inputs come from logic on clk_sys
// Notes: flooding transport, timers and acknowledgement tracking are outside
`timescale 1ns/1ns
`default_nettype none
module lsr_recency_unit
  import lsr_pkg::*;
#(
  parameter logic [15:0] MAX_AGE_DIFF = MAX_AGE_DIFF_DEF,
  parameter int LINK_IDX_W = 8
) (
  input wire logic clk_sys,
  input wire logic rstn,
  // Own record issue
  input wire logic issueReq,
  input wire logic ageExpired,
  input wire logic flushAcked,
  output logic floodValid,
  output logic [31:0] floodInc,
  output logic [15:0] floodAge,
  output logic flushPending,
  // Recency compare, A is the received copy
  input wire logic cmpReq,
  input wire logic [31:0] idA,
  input wire logic [31:0] idB,
  input wire logic [31:0] incA,
  input wire logic [31:0] incB,
  input wire logic [15:0] ageA,
  input wire logic [15:0] ageB,
  input wire logic [15:0] csumA,
  input wire logic [15:0] csumB,
  output logic cmpValid,
  output logic cmpIdentical,
  output logic cmpANewer,
  output logic cmpBNewer,
  // Checksum byte stream, age bytes excluded
  input wire logic byteValid,
  input wire logic byteFirst,
  input wire logic byteLast,
  input wire logic [7:0] byteData,
  input wire logic streamRx,
  input wire logic rxAbsent,
  output logic csumDone,
  output logic [15:0] csumValue,
  output logic csumOk,
  output logic storeRecord,
  output logic discardRecord,
  output logic dbCorrupt,
  // Link cost
  input wire logic costReq,
  input wire logic [LINK_IDX_W-1:0] costLinkIn,
  input wire logic [31:0] rateKbaud,
  input wire logic [7:0] costScale,
  output logic costValid,
  output logic [LINK_IDX_W-1:0] costLink,
  output logic [15:0] cost
);
  // Incarnation issue
  inc_state_t incState, next_incState;
  logic issued, next_issued;
  logic [31:0] next_floodInc;
  logic [15:0] next_floodAge;
  logic next_floodValid;

  always_comb begin
    next_incState = incState;
    next_issued = issued;
    next_floodInc = floodInc;
    next_floodAge = floodAge;
    next_floodValid = 1'b0;
    case (incState)
      INC_IDLE: begin
        if (issueReq) begin
          next_floodValid = 1'b1;
          next_issued = 1'b1;
          if (!issued) begin
            next_floodInc = INC_FIRST;
            next_floodAge = AGE_ZERO;
          end else if (floodInc == INC_MAX) begin
            next_floodAge = MAX_AGE;
            next_incState = INC_FLUSH;
          end else begin
            // Wrap skips the unused pattern by construction
            next_floodInc = floodInc + 32'h0000_0001;
            next_floodAge = AGE_ZERO;
          end
        end else if (ageExpired && issued) begin
          next_floodValid = 1'b1;
          next_floodAge = MAX_AGE;
        end
      end
      INC_FLUSH: begin
        if (flushAcked) begin
          next_floodValid = 1'b1;
          next_floodInc = INC_FIRST;
          next_floodAge = AGE_ZERO;
          next_incState = INC_IDLE;
        end
      end
      default: next_incState = INC_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      incState <= INC_IDLE;
      issued <= 1'b0;
      floodInc <= INC_FIRST;
      floodAge <= AGE_ZERO;
      floodValid <= 1'b0;
      flushPending <= 1'b0;
    end else begin
      incState <= next_incState;
      issued <= next_issued;
      floodInc <= next_floodInc;
      floodAge <= next_floodAge;
      floodValid <= next_floodValid;
      flushPending <= (next_incState == INC_FLUSH);
    end
  end

  // Recency compare
  logic next_cmpIdentical, next_cmpANewer, next_cmpBNewer;
  logic maxA, maxB;
  logic [15:0] ageDiff;

  always_comb begin
    maxA = (ageA == MAX_AGE);
    maxB = (ageB == MAX_AGE);
    ageDiff = (ageA > ageB) ? (ageA - ageB) : (ageB - ageA);
    next_cmpIdentical = 1'b0;
    next_cmpANewer = 1'b0;
    next_cmpBNewer = 1'b0;
    if ($signed(incA) > $signed(incB)) begin
      next_cmpANewer = 1'b1;
    end else if ($signed(incA) < $signed(incB)) begin
      next_cmpBNewer = 1'b1;
    end else if (maxA != maxB) begin
      next_cmpANewer = maxA;
      next_cmpBNewer = maxB;
    end else if (csumA != csumB) begin
      next_cmpANewer = (csumA > csumB);
      next_cmpBNewer = (csumA < csumB);
    end else if (ageA != ageB && ageDiff <= MAX_AGE_DIFF) begin
      next_cmpANewer = (ageA < ageB);
      next_cmpBNewer = (ageA > ageB);
    end else begin
      next_cmpIdentical = 1'b1;
    end
    if (idA == idB && incA == incB) begin
      // Identity is reported too when age or checksum differ, alongside any newer flag already set
      next_cmpIdentical = 1'b1;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cmpValid <= 1'b0;
      cmpIdentical <= 1'b0;
      cmpANewer <= 1'b0;
      cmpBNewer <= 1'b0;
    end else begin
      cmpValid <= cmpReq;
      if (cmpReq) begin
        cmpIdentical <= next_cmpIdentical;
        cmpANewer <= next_cmpANewer;
        cmpBNewer <= next_cmpBNewer;
      end
    end
  end

  // Checksum stream
  logic [15:0] bytePos, next_bytePos;
  logic [15:0] rxCsum, next_rxCsum;
  logic finalize, next_finalize;
  logic isRx, next_isRx, absent, next_absent;
  logic [7:0] feed, sum0, sum1;
  logic [31:0] kMod, xi, yi;
  logic [7:0] xb, yb;
  logic next_csumDone, next_csumOk, next_store, next_discard, next_corrupt;
  logic [15:0] next_csumValue;

  always_comb begin
    next_bytePos = bytePos;
    next_rxCsum = rxCsum;
    next_isRx = isRx;
    next_absent = absent;
    feed = byteData;
    if (byteValid) begin
      next_bytePos = (byteFirst ? 16'h0001 : bytePos + 16'h0001);
      if (byteFirst) begin
        next_isRx = streamRx;
        next_absent = rxAbsent;
      end
      if (next_bytePos == CSUM_POS_HI) begin
        next_rxCsum[15:8] = byteData;
        feed = CSUM_ZERO_BYTE;
      end else if (next_bytePos == CSUM_POS_LO) begin
        next_rxCsum[7:0] = byteData;
        feed = CSUM_ZERO_BYTE;
      end
    end
    next_finalize = byteValid && byteLast;
  end

  fletcher_accum u_fletcher (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .clear(byteValid && byteFirst),
    .step(byteValid),
    .data(feed),
    .sum0(sum0),
    .sum1(sum1)
  );

  always_comb begin
    // k counts bytes after the first check byte position
    kMod = 32'((bytePos - CSUM_POS_HI) % 16'h00FF);
    xi = (kMod * 32'(sum0) + 32'h0000_01FE - 32'(sum1)) % 32'h0000_00FF;
    yi = (32'(sum1) + 32'h0000_FE01 - (kMod + 32'h0000_0001) * 32'(sum0))
      % 32'h0000_00FF;
    xb = (xi[7:0] == 8'h00) ? 8'hFF : xi[7:0];
    yb = (yi[7:0] == 8'h00) ? 8'hFF : yi[7:0];
    next_csumDone = finalize;
    next_csumValue = finalize ? {xb, yb} : csumValue;
    next_csumOk = finalize ? ({xb, yb} == rxCsum) : csumOk;
    next_store = finalize && isRx && ({xb, yb} == rxCsum)
      && (absent || cmpANewer);
    next_discard = finalize && isRx && ({xb, yb} != rxCsum);
    next_corrupt = dbCorrupt || (finalize && !isRx
      && ({xb, yb} != rxCsum));
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      bytePos <= 16'h0000;
      rxCsum <= 16'h0000;
      isRx <= 1'b0;
      absent <= 1'b0;
      finalize <= 1'b0;
      csumDone <= 1'b0;
      csumValue <= 16'h0000;
      csumOk <= 1'b0;
      storeRecord <= 1'b0;
      discardRecord <= 1'b0;
      dbCorrupt <= 1'b0;
    end else begin
      bytePos <= next_bytePos;
      rxCsum <= next_rxCsum;
      isRx <= next_isRx;
      absent <= next_absent;
      finalize <= next_finalize;
      csumDone <= next_csumDone;
      csumValue <= next_csumValue;
      csumOk <= next_csumOk;
      storeRecord <= next_store;
      discardRecord <= next_discard;
      dbCorrupt <= next_corrupt;
    end
  end

  // Link cost: serial restoring divide, one link per request
  div_state_t divState, next_divState;
  logic [39:0] quo, next_quo;
  logic [40:0] rem, next_rem;
  logic [31:0] divisor, next_divisor;
  logic [5:0] divCnt, next_divCnt;
  logic [LINK_IDX_W-1:0] next_costLink;
  logic [15:0] next_cost;
  logic next_costValid;
  logic [7:0] scaleUse;
  logic [40:0] trial;

  always_comb begin
    next_divState = divState;
    next_quo = quo;
    next_rem = rem;
    next_divisor = divisor;
    next_divCnt = divCnt;
    next_costLink = costLink;
    next_cost = cost;
    next_costValid = 1'b0;
    scaleUse = (costScale == 8'h00) ? COST_SCALE_DEF : costScale;
    trial = {rem[39:0], quo[39]} - {9'h000, divisor};
    case (divState)
      DIV_IDLE: begin
        if (costReq) begin
          // Dividend shifts out of quo while quotient bits shift in
          next_quo = 40'(COST_NUM_KBAUD) * 40'(scaleUse);
          next_divisor = rateKbaud;
          next_rem = 41'h0;
          next_divCnt = 6'(DIV_STEPS);
          next_costLink = costLinkIn;
          next_divState = DIV_RUN;
        end
      end
      DIV_RUN: begin
        if (!trial[40]) begin
          next_rem = trial;
          next_quo = {quo[38:0], 1'b1};
        end else begin
          next_rem = {rem[39:0], quo[39]};
          next_quo = {quo[38:0], 1'b0};
        end
        next_divCnt = divCnt - 6'h01;
        if (divCnt == 6'h01) begin
          // Zero rate or oversized result saturates the 16-bit field
          next_cost = (divisor == 32'h0 || next_quo > 40'(COST_MAX))
            ? COST_MAX : next_quo[15:0];
          next_costValid = 1'b1;
          next_divState = DIV_IDLE;
        end
      end
      default: next_divState = DIV_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      divState <= DIV_IDLE;
      quo <= 40'h0;
      rem <= 41'h0;
      divisor <= 32'h0;
      divCnt <= 6'h0;
      costLink <= '0;
      cost <= 16'h0000;
      costValid <= 1'b0;
    end else begin
      divState <= next_divState;
      quo <= next_quo;
      rem <= next_rem;
      divisor <= next_divisor;
      divCnt <= next_divCnt;
      costLink <= next_costLink;
      cost <= next_cost;
      costValid <= next_costValid;
    end
  end
endmodule : lsr_recency_unit
`default_nettype wire

// file: verification/lsr_recency_properties.sv
// Purpose: port-level checks for the record recency unit
// Assumes: one clk_sys domain, rstn active low
// Notes: rollover checks only fire if a run reaches INC_MAX
`timescale 1ns/1ns
`default_nettype none
module lsr_recency_checker
  import lsr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic issueReq,
  input wire logic flushAcked,
  input wire logic floodValid,
  input wire logic [31:0] floodInc,
  input wire logic [15:0] floodAge,
  input wire logic flushPending,
  input wire logic cmpReq,
  input wire logic [31:0] idA,
  input wire logic [31:0] idB,
  input wire logic [31:0] incA,
  input wire logic [31:0] incB,
  input wire logic [15:0] ageA,
  input wire logic [15:0] ageB,
  input wire logic cmpValid,
  input wire logic cmpIdentical,
  input wire logic cmpANewer,
  input wire logic cmpBNewer,
  input wire logic csumDone,
  input wire logic csumOk,
  input wire logic storeRecord,
  input wire logic discardRecord,
  input wire logic costReq,
  input wire logic costValid
);
  logic issued;
  logic next_issued;
  always_comb next_issued = issued | floodValid;
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) issued <= 1'b0;
    else issued <= next_issued;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  a_first_inc: assert property (
    floodValid && !issued |-> floodInc == INC_FIRST)
    else $error("first flood incarnation wrong");
  a_inc_step: assert property (
    floodValid && issued && floodAge == AGE_ZERO && !$past(flushPending)
    |-> floodInc == $past(floodInc) + 32'h0000_0001)
    else $error("incarnation did not step by one");
  a_issue_answer: assert property (
    issueReq && !flushPending |=> floodValid)
    else $error("issue not flooded next cycle");
  a_inc_unused: assert property (
    floodValid |-> floodInc != INC_UNUSED)
    else $error("unused incarnation flooded");
  a_rollover_flush: assert property (
    issueReq && !flushPending && issued && floodInc == INC_MAX
    |=> floodValid && floodAge == MAX_AGE && flushPending)
    else $error("rollover flush missing");
  a_flush_reissue: assert property (
    flushPending && flushAcked |=> floodValid && floodInc == INC_FIRST
    && floodAge == AGE_ZERO && !flushPending)
    else $error("reissue after flush wrong");
  a_same_identical: assert property (
    cmpReq && idA == idB && incA == incB |=> cmpValid && cmpIdentical)
    else $error("identity not reported");
  a_signed_newer: assert property (
    cmpReq && $signed(incA) > $signed(incB)
    |=> cmpANewer && !cmpBNewer && !cmpIdentical)
    else $error("signed incarnation order wrong");
  a_ceiling_newer: assert property (
    cmpReq && incA == incB && ageB == MAX_AGE && ageA != MAX_AGE
    |=> cmpBNewer && !cmpANewer)
    else $error("ceiling age not preferred");
  a_discard_bad: assert property (
    discardRecord |-> csumDone && !csumOk && !storeRecord)
    else $error("discard without failed check");
  a_store_good: assert property (
    storeRecord |-> csumDone && csumOk)
    else $error("store without good check");
  a_cost_latency: assert property (
    costValid |-> $past(costReq, 41))
    else $error("cost answer latency wrong");
endmodule : lsr_recency_checker
bind lsr_recency_unit lsr_recency_checker lsr_recency_checker_inst (.*);
`default_nettype wire

// file: verification/link_peer_model.sv
// Purpose: neighbour switch sending one record byte stream
// Assumes: go is a one-cycle pulse after the previous record
// Notes: one link descriptor, 42 bytes with age bytes left out
`timescale 1ns/1ns
`default_nettype none
module link_peer_model (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic go,
  input wire logic corrupt,
  input wire logic slow,
  output logic byteValid,
  output logic byteFirst,
  output logic byteLast,
  output logic [7:0] byteData
);
  localparam int LEN = 42;
  int pos;
  int s0;
  int s1;
  int cx;
  int cy;
  logic gap;
  function automatic logic [7:0] body(input int p);
    return (p == 21 || p == 22) ? 8'h00 : 8'(p * 37 + 5);
  endfunction
  // Check bytes close both sums; negative mod folded back
  initial begin
    s0 = 0;
    s1 = 0;
    for (int p = 1; p <= LEN; p++) begin
      s0 = (s0 + body(p)) % 255;
      s1 = (s1 + s0) % 255;
    end
    cx = (((LEN - 21) * s0 - s1) % 255 + 255) % 255;
    cy = ((s1 - (LEN - 20) * s0) % 255 + 255) % 255;
    if (cx == 0) cx = 255;
    if (cy == 0) cy = 255;
  end
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      pos <= 0;
      gap <= 1'b0;
      byteValid <= 1'b0;
      byteFirst <= 1'b0;
      byteLast <= 1'b0;
      byteData <= 8'h00;
    end else begin
      byteValid <= 1'b0;
      byteFirst <= 1'b0;
      byteLast <= 1'b0;
      byteData <= ~byteData;
      gap <= slow && !gap;
      if (go) pos <= 1;
      else if (pos != 0 && !gap) begin
        byteValid <= 1'b1;
        byteFirst <= pos == 1;
        byteLast <= pos == LEN;
        byteData <= (pos == 21 ? 8'(cx) : pos == 22 ? 8'(cy) : body(pos))
          ^ ((corrupt && pos == 3) ? 8'h40 : 8'h00);
        pos <= (pos == LEN) ? 0 : pos + 1;
      end
    end
  end
endmodule : link_peer_model
`default_nettype wire

// file: verification/tb.sv
// Purpose: self-checking bench for the record recency unit
// Assumes: 20 MHz clk_sys, inputs driven by NBA on rising edge
// Notes: incarnation rollover is beyond run length, checker only
`timescale 1ns/1ns
`default_nettype none
module tb;
  import lsr_pkg::*;
  localparam logic [31:0] INC_A = 32'h8000_0004;
  logic clk_sys = 0, rstn = 0, issueReq = 0, ageExpired = 0;
  logic flushAcked = 0, floodValid, flushPending, cmpReq = 0;
  logic [31:0] floodInc, idA = 0, idB = 0, incA = 0, incB = 0;
  logic [15:0] floodAge, ageA = 0, ageB = 0, csumA = 0, csumB = 0;
  logic cmpValid, cmpIdentical, cmpANewer, cmpBNewer;
  logic byteValid, byteFirst, byteLast, streamRx = 0, rxAbsent = 0;
  logic [7:0] byteData, costScale = 0, costLinkIn = 0, costLink;
  logic csumDone, csumOk, storeRecord, discardRecord, dbCorrupt;
  logic [15:0] csumValue, cost;
  logic costReq = 0, costValid, go = 0, corrupt = 0, slow = 0;
  logic [31:0] rateKbaud = 0;
  logic [7:0] cap [1:42];
  int cpos = 1, n_errors = 0, checks_done = 0;
  lsr_recency_unit lsr_recency_unit_inst (.*);
  link_peer_model link_peer_model_inst (.*);
  always #25 clk_sys = ~clk_sys;
  always @(posedge clk_sys) begin
    if (byteValid) begin
      if (byteFirst) cpos = 1;
      if (cpos <= 42) cap[cpos] = byteData;
      cpos++;
    end
  end
  task automatic chk(input string what, input logic [31:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_errors++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic report_and_stop();
    if (n_errors == 0 && checks_done > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop
  task automatic flood(input bit aged, input logic [31:0] inc,
                       input logic [15:0] age);
    @(posedge clk_sys);
    issueReq <= !aged;
    ageExpired <= aged;
    @(posedge clk_sys);
    issueReq <= 1'b0;
    ageExpired <= 1'b0;
    #1 chk("floodValid", floodValid, 1'b1);
    chk("floodInc", floodInc, inc);
    chk("floodAge", floodAge, age);
    chk("flushPending", flushPending, 1'b0);
  endtask : flood
  task automatic cmp(input logic [31:0] ib, input logic [15:0] aa, ab,
                     ca, cb, input logic [2:0] exp);
    @(posedge clk_sys);
    cmpReq <= 1'b1;
    idA <= 32'h0000_0005;
    idB <= 32'h0000_0005;
    incA <= INC_A;
    incB <= ib;
    ageA <= aa;
    ageB <= ab;
    csumA <= ca;
    csumB <= cb;
    @(posedge clk_sys);
    cmpReq <= 1'b0;
    #1 chk("cmpValid", cmpValid, 1'b1);
    chk("cmpFlags", {cmpIdentical, cmpANewer, cmpBNewer}, exp);
  endtask : cmp
  // Sums over the whole carried stream must close to zero
  function automatic bit sums_zero();
    int a = 0;
    int b = 0;
    for (int p = 1; p <= 42; p++) begin
      a = (a + cap[p]) % 255;
      b = (b + a) % 255;
    end
    return a == 0 && b == 0;
  endfunction : sums_zero
  task automatic rec(input bit rx, absent, bad, slw, store);
    int k;
    bit ok;
    @(posedge clk_sys);
    streamRx <= rx;
    rxAbsent <= absent;
    corrupt <= bad;
    slow <= slw;
    go <= 1'b1;
    @(posedge clk_sys);
    go <= 1'b0;
    for (k = 0; k < 200; k++) begin
      @(posedge clk_sys);
      #1;
      if (csumDone === 1'b1) break;
    end
    if (k == 200) begin
      n_errors++;
      report_and_stop();
    end
    ok = sums_zero();
    chk("csumOk", csumOk, ok);
    if (ok) chk("csumValue", csumValue, {cap[21], cap[22]});
    chk("storeRecord", storeRecord, rx && ok && store);
    chk("discardRecord", discardRecord, rx && !ok);
    if (!rx) chk("dbCorrupt", dbCorrupt, !ok);
  endtask : rec
  task automatic cost_run(input logic [7:0] lk, sc, input logic [31:0] r,
                          input logic [15:0] exp);
    @(posedge clk_sys);
    costReq <= 1'b1;
    costLinkIn <= lk;
    costScale <= sc;
    rateKbaud <= r;
    @(posedge clk_sys);
    costReq <= 1'b0;
    repeat (39) @(posedge clk_sys);
    #1 chk("costEarly", costValid, 1'b0);
    @(posedge clk_sys);
    #1 chk("costValid", costValid, 1'b1);
    chk("costLink", costLink, lk);
    chk("cost", cost, exp);
  endtask : cost_run
  initial begin
    repeat (6) @(posedge clk_sys);
    rstn <= 1'b1;
    flood(0, INC_FIRST, AGE_ZERO);
    flood(0, INC_FIRST + 32'h0000_0001, AGE_ZERO);
    flood(1, INC_FIRST + 32'h0000_0001, MAX_AGE);
    cmp(32'h7FFF_0000, 16'h0000, 16'h0000, 16'h1234, 16'h1234, 3'b001);
    cmp(INC_FIRST, 16'h0000, 16'h0000, 16'h1234, 16'h1234, 3'b010);
    cmp(INC_A, MAX_AGE, 16'h0010, 16'h1234, 16'h1234, 3'b110);
    cmp(INC_A, 16'h0010, MAX_AGE, 16'h1234, 16'h1234, 3'b101);
    cmp(INC_A, 16'h0014, 16'h0014, 16'h1234, 16'hF000, 3'b101);
    cmp(INC_A, 16'h0064, 16'h0064 + MAX_AGE_DIFF_DEF, 16'h1234, 16'h1234,
        3'b110);
    cmp(INC_A, 16'h0064, 16'h0065 + MAX_AGE_DIFF_DEF, 16'h1234, 16'h1234,
        3'b100);
    rec(1, 1, 0, 0, 1);
    rec(1, 0, 0, 1, 0);
    cmp(INC_FIRST, 16'h0000, 16'h0000, 16'h1234, 16'h1234, 3'b010);
    rec(1, 0, 0, 0, 1);
    rec(1, 1, 1, 0, 0);
    rec(0, 0, 0, 1, 0);
    rec(0, 0, 1, 0, 0);
    cost_run(8'h03, 8'h00, 32'h0010_3664, 16'h03E8);
    cost_run(8'h05, 8'h02, 32'h0040_D990, 16'h01F4);
    cost_run(8'h07, 8'h01, 32'h0000_0000, 16'hFFFF);
    cost_run(8'h01, 8'hFF, 32'h0000_03E8, 16'hFFFF);
    report_and_stop();
  end
endmodule : tb
`default_nettype wire
